//--- acr_pkg.sv
/*
  acr_pkg: shared layout, reset values, mode codes and timing counts
  for the converter control and result block.
  Assumes the converter oscillator is the 200 MHz mclk of the block.
*/
package acr_pkg;

  // configuration word, bit 23 first down to bit 0
  typedef struct packed {
    logic        outputCodingSel;   // 1: two's complement, 0: offset binary
    logic [10:0] notchCode;         // decimation code
    logic [2:0]  opModeSel;         // operating mode
    logic        bipolarSel;        // 1: bipolar, 0: unipolar
    logic [2:0]  gainCode;          // total gain 1..128
    logic        burnoutSourceEn;   // open-input current source
    logic        standbyEn;         // halt filter and modulator
    logic        byteOrderDir;      // 1: ascending byte steps
    logic        lsbFirstSel;       // 1: each byte least significant first
    logic        readLineSel;       // 1: reads on the separate output line
  } acr_cfg_s;

  // one serial byte headed for a register in the mclk domain
  typedef struct packed {
    logic [1:0] regSel;
    logic [1:0] byteIdx;
    logic [7:0] data;
  } acr_wr_s;

  typedef enum logic [1:0] {SEQ_STBY, SEQ_CAL, SEQ_SETTLE, SEQ_RUN} acr_seq_e;

  localparam int RES_W = 24;

  // register select codes of the instruction byte
  localparam logic [1:0] REG_DATA = 2'h0;
  localparam logic [1:0] REG_CFG  = 2'h1;

  // operating mode codes; codes above 3'h4 run as plain conversion
  localparam logic [2:0] MODE_CONVERT        = 3'h0;
  localparam logic [2:0] MODE_SELF_CAL       = 3'h1;
  localparam logic [2:0] MODE_SYS_OFFSET_CAL = 3'h2;
  localparam logic [2:0] MODE_SYS_POS_CAL    = 3'h3;
  localparam logic [2:0] MODE_SYS_NEG_CAL    = 3'h4;

  localparam logic [10:0] NOTCH_MIN   = 11'h00a;
  localparam logic [10:0] NOTCH_RESET = 11'h064;
  localparam logic [2:0]  GAIN_ANALOG_MAX = 3'h3;

  localparam acr_cfg_s CFG_RESET = '{
    outputCodingSel: 1'b0, notchCode: NOTCH_RESET, opModeSel: MODE_SELF_CAL,
    bipolarSel: 1'b1, gainCode: 3'h0, burnoutSourceEn: 1'b0,
    standbyEn: 1'b0, byteOrderDir: 1'b0, lsbFirstSel: 1'b0,
    readLineSel: 1'b0};

  // word timing, in oscillator periods per unit of notch code
  localparam int OSC_PER_CODE = 512;
  localparam int PERIOD_W     = 20;
  localparam int CAL_WORDS    = 2;
  localparam int SETTLE_WORDS = 3;

  // minimum high time of the ready output after a completed read
  localparam int MCLK_PERIOD_NS = 5;
  localparam int RDY_HIGH_NS    = 20;
  localparam int RDY_HIGH_CYC   =
    (RDY_HIGH_NS + MCLK_PERIOD_NS - 1) / MCLK_PERIOD_NS;

endpackage

//--- acr_ctrl_result.sv
/*
  acr_ctrl_result: configuration word, conversion sequencer, result
  register with one-entry backup buffer, ready output and the serial
  register port (chip select, serial clock, data in/out lines).
  Assumes filterWord is produced on mclk and that the serial clock only
  runs while chip select is low; serial frame state restarts with every frame, byte toggles persist.
*/
`timescale 1ns/100ps

// How it works
// - result register is read-only; serial writes to it are dropped
// - 24-bit read/write configuration word with the documented bit fields
// - coding bit picks two's complement or offset binary; unipolar is straight
// - word period is 512 times notch code oscillator cycles; code 10..2047
// - one new conversion word per word period
// - after a restart the first words are discarded while the filter settles
// - three-bit mode field; reset selects self-calibration
// - polarity bit selects bipolar when one; reset sets it
// - gain codes 0..3 analog only; higher codes analog 8 plus digital shift
// - burn-out bit drives the positive input current source enable
// - standby halts filter, holds ready high, stops modulator clock
// - byte-direction bit steps multi-byte accesses up or down
// - bit-order bit sends and receives each byte lsb or msb first
// - read-line bit moves read data from the two-way line to the output line
// - ready goes low once a valid result sits in the result register
// - a result being read is never overwritten and ready stays low
// - a one-entry buffer catches the next word during a read
// - a late read drops word X+1 and keeps X+2 in the buffer
// - finished read raises ready; buffer moves in once chip select is high, ready falls after minimum high time
// - with the output line selected all read data leaves on it
// - writing byte 2 or 1 raises ready and restarts the sequence, calibrating first only if the mode held before that byte's write is 1..4
module acr_ctrl_result #(
  parameter int OSC_PER_CODE = acr_pkg::OSC_PER_CODE
) (
  input  wire logic             mclk,
  input  wire logic             nrst,
  input  wire logic [23:0]      filterWord,
  input  wire logic             sclk,
  input  wire logic             csN,
  input  wire logic             sdioIn,
  output logic                  sdioOut,
  output logic                  sdioOe,
  output logic                  serialOutLine,
  output logic                  serialOutLineOe,
  output logic                  resultReadyN,
  output logic                  burnoutSourceEn,
  output logic                  modulatorClkEn,
  output logic [2:0]            ampGainCode,
  output logic                  calibrating,
  output acr_pkg::acr_cfg_s     cfgOut
);

  localparam int PERIOD_W_L = acr_pkg::PERIOD_W;

  acr_pkg::acr_cfg_s cfg_r;
  acr_pkg::acr_seq_e seq_r;
  acr_pkg::acr_wr_s  wrXfer_r;
  logic [23:0]       resultReg_r;
  logic [23:0]       bufReg_r;
  logic              bufFull_r;
  logic              fresh_r;
  logic [2:0]        hiCnt_r;
  logic              rdyN_r;
  logic              modClk_r;
  logic [2:0]        ampGain_r;
  logic [PERIOD_W_L-1:0] wordCnt_r;
  logic [2:0]        words_r;
  logic [1:0]        csSync_r;
  logic [2:0]        wrSync_r;
  logic [2:0]        rdSync_r;
  logic              wrTog_r;
  logic              rdTog_r;
  // serial clock domain
  logic [2:0]        bitCnt_r;
  logic              inData_r;
  logic              done_r;
  logic [7:0]        instr_r;
  logic [7:0]        shift_r;
  logic [1:0]        byteIdx_r;
  logic [1:0]        bytesLeft_r;
  logic              sdioOut_r;
  logic              sdioOe_r;
  logic              sdoOut_r;
  logic              sdoOe_r;

  logic              frameActive;
  logic              wrEvt;
  logic              rdEvt;
  logic              cfgRestart;
  logic              restart;
  logic              wordEnd;
  logic              convDone;
  logic              isCalMode;
  logic [10:0]       effCode;
  logic [PERIOD_W_L-1:0] period;
  logic [23:0]       codedWord;
  logic              frameRst;
  logic              byteDone;
  logic [7:0]        shNxt;
  logic [7:0]        txByte;
  logic [2:0]        txPos;
  logic              rdActive;

  // scale by the digital gain step and apply the output coding
  function automatic logic [23:0] codeWord(input logic [23:0] raw,
                                           input acr_pkg::acr_cfg_s c);
    logic [2:0]         sh;
    logic signed [27:0] sw;
    logic [27:0]        uw;
    logic [23:0]        v;
    sh = 3'h0;
    sw = '0;
    uw = '0;
    v  = '0;
    if (c.gainCode > acr_pkg::GAIN_ANALOG_MAX) begin
      sh = c.gainCode - acr_pkg::GAIN_ANALOG_MAX;
    end
    if (c.bipolarSel) begin
      sw = signed'({{4{raw[23]}}, raw}) <<< sh;
      if (sw > 28'sh07fffff) begin
        v = 24'h7fffff;
      end else if (sw < -28'sh0800000) begin
        v = 24'h800000;
      end else begin
        v = sw[23:0];
      end
      if (!c.outputCodingSel) begin
        v[23] = ~v[23];
      end
    end else begin
      uw = {4'h0, raw} << sh;
      v  = (|uw[27:24]) ? 24'hffffff : uw[23:0];
    end
    return v;
  endfunction

  // serial events reach mclk as toggles; chip select as a level
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      csSync_r <= 2'h3;
      wrSync_r <= 3'h0;
      rdSync_r <= 3'h0;
    end else begin
      csSync_r <= {csSync_r[0], csN};
      wrSync_r <= {wrSync_r[1:0], wrTog_r};
      rdSync_r <= {rdSync_r[1:0], rdTog_r};
    end
  end

  assign frameActive = ~csSync_r[1];
  assign wrEvt       = wrSync_r[2] ^ wrSync_r[1];
  assign rdEvt       = rdSync_r[2] ^ rdSync_r[1];

  // configuration writes; a write to the result register is dropped
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      cfg_r <= acr_pkg::CFG_RESET;
    end else if (wrEvt && wrXfer_r.regSel == acr_pkg::REG_CFG) begin
      case (wrXfer_r.byteIdx)
        2'h0:    cfg_r[7:0]   <= wrXfer_r.data;
        2'h1:    cfg_r[15:8]  <= wrXfer_r.data;
        2'h2:    cfg_r[23:16] <= wrXfer_r.data;
        default: cfg_r        <= cfg_r;
      endcase
    end
  end

  assign cfgRestart = wrEvt && wrXfer_r.regSel == acr_pkg::REG_CFG &&
                      (wrXfer_r.byteIdx == 2'h1 ||
                       wrXfer_r.byteIdx == 2'h2);
  assign restart    = cfgRestart || seq_r == acr_pkg::SEQ_STBY;
  assign isCalMode  = cfg_r.opModeSel >= acr_pkg::MODE_SELF_CAL &&
                      cfg_r.opModeSel <= acr_pkg::MODE_SYS_NEG_CAL;
  // codes below the minimum would run faster than the filter supports
  assign effCode    = (cfg_r.notchCode < acr_pkg::NOTCH_MIN) ?
                      acr_pkg::NOTCH_MIN : cfg_r.notchCode;
  assign period     = PERIOD_W_L'(OSC_PER_CODE) *
                      PERIOD_W_L'(effCode);
  assign wordEnd    = wordCnt_r == PERIOD_W_L'(period - 1'b1);
  assign convDone   = seq_r == acr_pkg::SEQ_RUN && wordEnd &&
                      !restart && !cfg_r.standbyEn;
  assign codedWord  = codeWord(filterWord, cfg_r);

  // sequencer: calibrate if asked, let the filter settle, then convert
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      seq_r     <= acr_pkg::SEQ_CAL;
      wordCnt_r <= '0;
      words_r   <= 3'h0;
    end else if (cfg_r.standbyEn) begin
      seq_r     <= acr_pkg::SEQ_STBY;
      wordCnt_r <= '0;
      words_r   <= 3'h0;
    end else if (restart) begin
      seq_r     <= isCalMode ? acr_pkg::SEQ_CAL : acr_pkg::SEQ_SETTLE;
      wordCnt_r <= '0;
      words_r   <= 3'h0;
    end else begin
      wordCnt_r <= wordEnd ? '0 : PERIOD_W_L'(wordCnt_r + 1'b1);
      if (wordEnd) begin
        words_r <= 3'(words_r + 1'b1);
        case (seq_r)
          acr_pkg::SEQ_CAL: begin
            if (words_r == 3'(acr_pkg::CAL_WORDS - 1)) begin
              seq_r   <= acr_pkg::SEQ_SETTLE;
              words_r <= 3'h0;
            end
          end
          acr_pkg::SEQ_SETTLE: begin
            if (words_r == 3'(acr_pkg::SETTLE_WORDS - 1)) begin
              seq_r   <= acr_pkg::SEQ_RUN;
              words_r <= 3'h0;
            end
          end
          acr_pkg::SEQ_RUN: words_r <= 3'h0;
          default:          seq_r   <= acr_pkg::SEQ_STBY;
        endcase
      end
    end
  end

  // result register and backup buffer; a load wins over a read's clear
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      resultReg_r <= 24'h000000;
      bufReg_r    <= 24'h000000;
      bufFull_r   <= 1'b0;
      fresh_r     <= 1'b0;
      hiCnt_r     <= 3'h0;
    end else if (restart || cfg_r.standbyEn) begin
      bufFull_r <= 1'b0;
      fresh_r   <= 1'b0;
      hiCnt_r   <= 3'h0;
    end else begin
      if (hiCnt_r != 3'h0) begin
        hiCnt_r <= 3'(hiCnt_r - 1'b1);
      end
      if (rdEvt) begin
        fresh_r <= 1'b0;
        hiCnt_r <= 3'(acr_pkg::RDY_HIGH_CYC);
      end
      if (convDone && frameActive) begin
        bufReg_r  <= codedWord;
        bufFull_r <= 1'b1;
      end else if (convDone) begin
        resultReg_r <= codedWord;
        bufFull_r   <= 1'b0;
        fresh_r     <= 1'b1;
      end else if (bufFull_r && !frameActive) begin
        resultReg_r <= bufReg_r;
        bufFull_r   <= 1'b0;
        fresh_r     <= 1'b1;
      end
    end
  end

  // outputs from flops; ready low only for an unread result
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdyN_r    <= 1'b1;
      modClk_r  <= 1'b0;
      ampGain_r <= 3'h0;
    end else begin
      rdyN_r    <= !(fresh_r && hiCnt_r == 3'h0 && !cfg_r.standbyEn);
      modClk_r  <= !cfg_r.standbyEn;
      ampGain_r <= (cfg_r.gainCode > acr_pkg::GAIN_ANALOG_MAX) ?
                   acr_pkg::GAIN_ANALOG_MAX : cfg_r.gainCode;
    end
  end

  assign resultReadyN    = rdyN_r;
  assign modulatorClkEn  = modClk_r;
  assign ampGainCode     = ampGain_r;
  assign burnoutSourceEn = cfg_r.burnoutSourceEn;
  assign calibrating     = seq_r == acr_pkg::SEQ_CAL;
  assign cfgOut          = cfg_r;

  // serial side: frame state restarts whenever chip select is high
  assign frameRst = csN | ~nrst;
  assign byteDone = bitCnt_r == 3'h7;
  assign shNxt    = cfg_r.lsbFirstSel ? {sdioIn, shift_r[7:1]} :
                                        {shift_r[6:0], sdioIn};

  always_ff @(posedge sclk or posedge frameRst) begin
    if (frameRst) begin
      bitCnt_r    <= 3'h0;
      inData_r    <= 1'b0;
      done_r      <= 1'b0;
      instr_r     <= 8'h00;
      shift_r     <= 8'h00;
      byteIdx_r   <= 2'h0;
      bytesLeft_r <= 2'h0;
    end else if (!done_r) begin
      shift_r  <= shNxt;
      bitCnt_r <= 3'(bitCnt_r + 1'b1);
      if (byteDone && !inData_r) begin
        inData_r    <= 1'b1;
        instr_r     <= shNxt;
        byteIdx_r   <= shNxt[1:0];
        bytesLeft_r <= shNxt[6:5];
      end else if (byteDone) begin
        byteIdx_r <= cfg_r.byteOrderDir ? 2'(byteIdx_r + 1'b1) :
                                          2'(byteIdx_r - 1'b1);
        if (bytesLeft_r == 2'h0) begin
          done_r <= 1'b1;
        end else begin
          bytesLeft_r <= 2'(bytesLeft_r - 1'b1);
        end
      end
    end
  end

  // finished bytes leave as toggles; these persist across frames
  always_ff @(posedge sclk or negedge nrst) begin
    if (!nrst) begin
      wrXfer_r <= '0;
      wrTog_r  <= 1'b0;
      rdTog_r  <= 1'b0;
    end else if (byteDone && inData_r && !done_r && !csN) begin
      if (instr_r[7]) begin
        wrXfer_r <= '{regSel: instr_r[3:2], byteIdx: byteIdx_r, data: shNxt};
        wrTog_r  <= ~wrTog_r;
      end else if (instr_r[3:2] == acr_pkg::REG_DATA &&
                   bytesLeft_r == 2'h0) begin
        rdTog_r <= ~rdTog_r;
      end
    end
  end

  // result is frozen by mclk for the whole frame, so it is stable here
  always_comb begin
    txByte = 8'h00;
    case (instr_r[3:2])
      acr_pkg::REG_DATA: begin
        if (byteIdx_r != 2'h3) txByte = resultReg_r[8*byteIdx_r +: 8];
      end
      acr_pkg::REG_CFG: begin
        if (byteIdx_r != 2'h3) txByte = cfg_r[8*byteIdx_r +: 8];
      end
      default: txByte = 8'h00;
    endcase
  end

  assign txPos    = cfg_r.lsbFirstSel ? bitCnt_r : 3'(3'h7 - bitCnt_r);
  assign rdActive = inData_r && !instr_r[7] && !done_r;

  // read data changes on the falling serial clock edge
  always_ff @(negedge sclk or posedge frameRst) begin
    if (frameRst) begin
      sdioOut_r <= 1'b0;
      sdioOe_r  <= 1'b0;
      sdoOut_r  <= 1'b0;
      sdoOe_r   <= 1'b0;
    end else begin
      sdioOut_r <= rdActive && !cfg_r.readLineSel && txByte[txPos];
      sdioOe_r  <= rdActive && !cfg_r.readLineSel;
      sdoOut_r  <= rdActive && cfg_r.readLineSel && txByte[txPos];
      sdoOe_r   <= rdActive && cfg_r.readLineSel;
    end
  end

  assign sdioOut         = sdioOut_r;
  assign sdioOe          = sdioOe_r;
  assign serialOutLine   = sdoOut_r;
  assign serialOutLineOe = sdoOe_r;

  // helper: cycles between successive words
  logic [PERIOD_W_L-1:0] gapCnt_r;
  logic                  gapValid_r;
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      gapCnt_r   <= '0;
      gapValid_r <= 1'b0;
    end else begin
      gapCnt_r   <= convDone ? '0 : PERIOD_W_L'(gapCnt_r + 1'b1);
      gapValid_r <= convDone || (gapValid_r && !restart);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  chk_standby_ready: assert property (
    cfg_r.standbyEn |=> resultReadyN && !modulatorClkEn)
    else $error("standby did not raise ready or stop modulator");
  chk_result_frozen: assert property (
    frameActive |=> $stable(resultReg_r))
    else $error("result changed during a frame");
  chk_buffer_catch: assert property (
    convDone && frameActive |=> bufFull_r && bufReg_r == $past(codedWord))
    else $error("word during read not buffered");
  chk_read_raises: assert property (
    rdEvt |-> ##2 resultReadyN)
    else $error("completed read did not raise ready");
  chk_min_high: assert property (
    $rose(resultReadyN) |-> resultReadyN[*4])
    else $error("ready high pulse too short");
  chk_ready_low: assert property (
    convDone && !frameActive && hiCnt_r == 3'h0 && !rdEvt ##1
    (!rdEvt && !cfg_r.standbyEn) |=> !resultReadyN)
    else $error("ready not low after new result");
  chk_word_period: assert property (
    convDone && gapValid_r |-> gapCnt_r == PERIOD_W_L'(period - 1'b1))
    else $error("word interval differs from period");
  chk_byte_restart: assert property (
    cfgRestart |-> ##2 resultReadyN ##0 seq_r != acr_pkg::SEQ_RUN)
    else $error("byte 2 or 1 write did not restart");
  chk_notch_clamp: assert property (
    period >= PERIOD_W_L'(OSC_PER_CODE) * PERIOD_W_L'(acr_pkg::NOTCH_MIN))
    else $error("period below minimum notch code");
  chk_cfg_write: assert property (
    wrEvt && wrXfer_r.regSel == acr_pkg::REG_CFG &&
    wrXfer_r.byteIdx == 2'h0 |=> cfg_r[7:0] == $past(wrXfer_r.data))
    else $error("configuration byte 0 not written");
  chk_read_line: assert property (
    @(negedge sclk) disable iff (frameRst)
    sdioOe_r |-> !serialOutLineOe && !cfg_r.readLineSel)
    else $error("read data on wrong line");

  cov_buffered: cover property (convDone && frameActive);
  cov_buf_move: cover property (rdEvt && bufFull_r);
  cov_restart:  cover property (cfgRestart);
  cov_cal_end:  cover property ($fell(calibrating));

endmodule // acr_ctrl_result

//--- acr_host_model.sv
/*
  acr_host_model: host processor on the serial port of the block.
  Assumes the bench calls frame() and wires these lines to the block.
*/
`timescale 1ns/100ps
module acr_host_model (
  output logic        sclk,
  output logic        csN,
  output logic        sdioIn,
  input  wire logic   sdioOut,
  input  wire logic   sdioOe,
  input  wire logic   serialOutLine,
  input  wire logic   serialOutLineOe,
  output logic [31:0] rdData,
  output logic        rdValid
);
  localparam real HALF = 62.5;
  logic hostOe = 1'b0;
  logic hostBit = 1'b0;
  logic lastBit = 1'b0;

  // released line shows the inverse of its last level, never a stale one
  assign sdioIn = sdioOe ? sdioOut : (hostOe ? hostBit : ~lastBit);
  always @(posedge sclk) lastBit <= sdioIn;

  initial begin
    sclk = 1'b1;
    csN = 1'b1;
    rdData = '0;
    rdValid = 1'b0;
  end

  // one frame; clock idles high and stands still outside frames
  task automatic frame(input logic [7:0] instr, input logic [31:0] wr,
                       input logic lsbF, input logic useOut, input logic chk);
    int n;
    logic [7:0] v;
    logic [7:0] got;
    n = int'(instr[6:5]) + 1;
    rdData = '0;
    csN = 1'b0;
    #HALF;
    for (int b = 0; b <= n; b++) begin
      v = (b == 0) ? instr : wr[31 - 8 * (b - 1) -: 8];
      for (int i = 0; i < 8; i++) begin
        sclk = 1'b0;
        hostOe = (b == 0) || instr[7];
        hostBit = lsbF ? v[i] : v[7 - i];
        #HALF;
        sclk = 1'b1;
        got[lsbF ? i : 7 - i] = useOut ?
          (serialOutLineOe ? serialOutLine : ~serialOutLine) : sdioIn;
        #HALF;
      end
      if (b > 0) rdData = {rdData[23:0], got};
    end
    #HALF;
    csN = 1'b1;
    hostOe = 1'b0;
    rdValid = chk && !instr[7];
    #HALF;
    rdValid = 1'b0;
    #(4 * HALF);
  endtask
endmodule // acr_host_model

//--- acr_ctrl_result_tb.sv
/*
  acr_ctrl_result_tb: self-checking bench of the control/result block.
  Assumes acr_pkg and acr_host_model; word period shortened by OSC.
*/
`timescale 1ns/100ps
module acr_ctrl_result_tb;
  localparam int OSC = 2;
  logic              mclk = 1'b0;
  logic              nrst;
  logic [23:0]       filterWord;
  logic              sclk, csN, sdioIn, sdioOut, sdioOe;
  logic              serialOutLine, serialOutLineOe, resultReadyN;
  logic              burnoutSourceEn, modulatorClkEn, calibrating;
  logic [2:0]        ampGainCode;
  acr_pkg::acr_cfg_s cfgOut, cfg;
  logic [31:0]       rdData;
  logic              rdValid;
  logic [23:0]       lfsr, e;
  logic [23:0]       expQ[$];
  int                nMismatch = 0;
  int                testsRun = 0;

  always #2.5 mclk = ~mclk;

  acr_ctrl_result #(.OSC_PER_CODE(OSC)) dut_u (.mclk(mclk), .nrst(nrst),
    .filterWord(filterWord), .sclk(sclk), .csN(csN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .serialOutLine(serialOutLine),
    .serialOutLineOe(serialOutLineOe), .resultReadyN(resultReadyN),
    .burnoutSourceEn(burnoutSourceEn), .modulatorClkEn(modulatorClkEn),
    .ampGainCode(ampGainCode), .calibrating(calibrating), .cfgOut(cfgOut));

  acr_host_model host_u (.sclk(sclk), .csN(csN), .sdioIn(sdioIn),
    .sdioOut(sdioOut), .sdioOe(sdioOe), .serialOutLine(serialOutLine),
    .serialOutLineOe(serialOutLineOe), .rdData(rdData), .rdValid(rdValid));

  function automatic logic [23:0] lfsrNext(input logic [23:0] s);
    return {s[22:0], s[23] ^ s[22] ^ s[21] ^ s[16]};
  endfunction

  task automatic endOfTest;
    if (nMismatch == 0 && testsRun > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [23:0] got, input logic [23:0] exp);
    testsRun++;
    if (got !== exp) begin
      nMismatch++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  // every host read made with chk set is matched against the oldest note
  always @(posedge rdValid) begin
    if (expQ.size() == 0) check(rdData[23:0], ~rdData[23:0]);
    else check(rdData[23:0], expQ.pop_front());
  end

  // bounded wait for the ready output to go low
  task automatic waitRdy;
    int k;
    k = 0;
    while (resultReadyN !== 1'b0 && k < 40000) begin
      @(negedge mclk);
      k++;
    end
    if (k >= 40000) begin
      nMismatch++;
      endOfTest();
    end
  endtask

  // first read may carry an older word, so only the second is judged
  task automatic getRes(input logic [7:0] ins, input logic [23:0] exp,
                        input logic lsb, input logic useOut);
    waitRdy();
    host_u.frame(ins, '0, lsb, useOut, 1'b0);
    waitRdy();
    expQ.push_back(exp);
    host_u.frame(ins, '0, lsb, useOut, 1'b1);
  endtask

  task automatic newWord(input logic [23:0] mask);
    lfsr = lfsrNext(lfsr);
    @(negedge mclk);
    filterWord = lfsr & mask;
  endtask

  initial begin
    nrst = 1'b0;
    filterWord = 24'h000000;
    lfsr = 24'h000016;
    repeat (6) @(negedge mclk);
    nrst = 1'b1;
    repeat (4) @(negedge mclk);
    check(cfgOut, acr_pkg::CFG_RESET);
    check(24'(calibrating), 24'h000001);
    expQ.push_back(acr_pkg::CFG_RESET);
    host_u.frame(8'h46, '0, 1'b0, 1'b0, 1'b1);
    // too small a notch code reads back as written
    cfg = acr_pkg::CFG_RESET;
    cfg.notchCode = 11'h005;
    cfg.opModeSel = acr_pkg::MODE_CONVERT;
    cfg.outputCodingSel = 1'b1;
    host_u.frame(8'hc6, {cfg, 8'h00}, 1'b0, 1'b0, 1'b0);
    expQ.push_back(cfg);
    host_u.frame(8'h46, '0, 1'b0, 1'b0, 1'b1);
    cfg.notchCode = 11'h3e8;
    host_u.frame(8'hc6, {cfg, 8'h00}, 1'b0, 1'b0, 1'b0);
    check(24'(resultReadyN), 24'h000001);
    newWord(24'hffffff);
    getRes(8'h42, filterWord, 1'b0, 1'b0);
    cfg.outputCodingSel = 1'b0;
    host_u.frame(8'h86, {cfg[23:16], 24'h0}, 1'b0, 1'b0, 1'b0);
    getRes(8'h42, filterWord ^ 24'h800000, 1'b0, 1'b0);
    // a byte-0 write leaves ready low; gain code 5 caps the analog gain code at 3
    waitRdy();
    cfg.gainCode = 3'h5;
    host_u.frame(8'h84, {cfg[7:0], 24'h0}, 1'b0, 1'b0, 1'b0);
    check(24'(resultReadyN), 24'h000000);
    check(24'(ampGainCode), 24'h000003);
    cfg.bipolarSel = 1'b0;
    host_u.frame(8'h85, {cfg[15:8], 24'h0}, 1'b0, 1'b0, 1'b0);
    newWord(24'h3fffff);
    e = filterWord << 2;
    getRes(8'h42, e, 1'b0, 1'b0);
    // writes to the result register change nothing
    waitRdy();
    host_u.frame(8'hc2, {~e, 8'h00}, 1'b0, 1'b0, 1'b0);
    expQ.push_back(e);
    host_u.frame(8'h42, '0, 1'b0, 1'b0, 1'b1);
    cfg.burnoutSourceEn = 1'b1;
    cfg.standbyEn = 1'b1;
    host_u.frame(8'h84, {cfg[7:0], 24'h0}, 1'b0, 1'b0, 1'b0);
    check(24'(burnoutSourceEn), 24'h000001);
    check(24'(modulatorClkEn), 24'h000000);
    check(24'(resultReadyN), 24'h000001);
    cfg.standbyEn = 1'b0;
    cfg.byteOrderDir = 1'b1;
    cfg.lsbFirstSel = 1'b1;
    host_u.frame(8'h84, {cfg[7:0], 24'h0}, 1'b0, 1'b0, 1'b0);
    getRes(8'h40, {e[7:0], e[15:8], e[23:16]}, 1'b1, 1'b0);
    cfg.readLineSel = 1'b1;
    host_u.frame(8'h84, {cfg[7:0], 24'h0}, 1'b1, 1'b0, 1'b0);
    check(cfgOut, cfg);
    getRes(8'h40, {e[7:0], e[15:8], e[23:16]}, 1'b1, 1'b1);
    endOfTest();
  end
endmodule // acr_ctrl_result_tb
